// ### common/mem_size_pkg.sv
package mem_size_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] MEMORY_SIZE_SELECT_ADDR = 16'hfff0;
  localparam logic [15:0] EXPANSION_RAM_SIZE_SELECT_ADDR = 16'hfff4;
  localparam logic [7:0] MEMORY_SIZE_SELECT_RESET = 8'hcf;
  localparam logic [7:0] EXPANSION_RAM_SIZE_SELECT_RESET = 8'h0c;
  // Field positions
  localparam int RAM_SEL_MSB = 7;
  localparam int RAM_SEL_LSB = 5;
  localparam int UNUSED_BIT = 4;
  localparam int ROM_SEL_MSB = 3;
  localparam int XRAM_SEL_MSB = 4;
  // Fast work memory codes
  localparam logic [2:0] RAM_CODE_512 = 3'h2;
  localparam logic [2:0] RAM_CODE_1024 = 3'h6;
  // Program store codes
  localparam logic [3:0] ROM_CODE_8K = 4'h2;
  localparam logic [3:0] ROM_CODE_16K = 4'h4;
  localparam logic [3:0] ROM_CODE_24K = 4'h6;
  localparam logic [3:0] ROM_CODE_32K = 4'h8;
  localparam logic [3:0] ROM_CODE_48K = 4'hc;
  localparam logic [3:0] ROM_CODE_60K = 4'hf;
  // Extra memory codes
  localparam logic [4:0] XRAM_CODE_NONE = 5'h0c;
  localparam logic [4:0] XRAM_CODE_1024 = 5'h0a;
  // Capacities in bytes
  localparam logic [16:0] KB = 17'h00400;
  localparam logic [16:0] ROM_BYTES_8K = 17'h02000;
  localparam logic [16:0] ROM_BYTES_16K = 17'h04000;
  localparam logic [16:0] ROM_BYTES_24K = 17'h06000;
  localparam logic [16:0] ROM_BYTES_32K = 17'h08000;
  localparam logic [16:0] ROM_BYTES_48K = 17'h0c000;
  localparam logic [16:0] ROM_BYTES_60K = 17'h0f000;
  localparam logic [10:0] RAM_BYTES_512 = 11'h200;
  localparam logic [10:0] RAM_BYTES_1024 = 11'h400;
  // High-speed RAM ends just below the special function area
  localparam logic [15:0] RAM_TOP = 16'hff00;
  localparam logic [15:0] XRAM_BASE = 16'hf400;
endpackage : mem_size_pkg

// ### rtl/memory_size_config_regs.sv
// Behaviour
// - Reset loads memory size select 0xCF
// - Memory size select written whole byte, bit 4 always stored as 0
// - Bits 7:5 pick 512 or 1024 RAM
// - Bits 3:0 pick ROM size
// - Reset loads expansion size select 0x0C
// - Expansion size select keeps written bits 4:0, bits 7:5 stored as 0
// - Code 0x0A enables 1024 bytes expansion
`timescale 1ns/1ps
`default_nettype none
module memory_size_config_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Processor memory write / read
  input wire logic [mem_size_pkg::ADDR_W-1:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [mem_size_pkg::DATA_W-1:0] wr_data,
  output logic [mem_size_pkg::DATA_W-1:0] rd_data,
  output logic rd_hit,
  // Address to classify
  input wire logic [mem_size_pkg::ADDR_W-1:0] probe_addr,
  // Decoder results
  output logic [16:0] rom_bytes,
  output logic [10:0] ram_bytes,
  output logic xram_en,
  output logic in_rom,
  output logic in_ram,
  output logic in_xram,
  output logic sel_illegal
);
  import mem_size_pkg::*;

  logic [7:0] memory_size_select_r;
  logic [7:0] expansion_ram_size_select_r;
  logic [16:0] rom_nxt;
  logic [10:0] ram_nxt;
  logic illegal_nxt;
  logic xram_nxt;
  // Access strobes, one per register and direction
  logic msel_wr;
  logic xsel_wr;
  logic msel_rd;
  logic xsel_rd;
  // Named fields of the two select registers
  logic fast_work_memory_size_bit2;
  logic fast_work_memory_size_bit1;
  logic fast_work_memory_size_bit0;
  logic program_store_size_bit3;
  logic program_store_size_bit2;
  logic program_store_size_bit1;
  logic program_store_size_bit0;
  logic extra_memory_size_bit4;
  logic extra_memory_size_bit3;
  logic extra_memory_size_bit2;
  logic extra_memory_size_bit1;
  logic extra_memory_size_bit0;
  // Per-field prohibited-code flags
  logic rom_bad;
  logic ram_bad;
  logic xram_bad;
  // Probe windows
  logic [15:0] ram_base;
  logic [15:0] xram_top;
  logic rom_hit_nxt;
  logic ram_hit_nxt;
  logic xram_hit_nxt;

  assign msel_wr = wr_en && addr == MEMORY_SIZE_SELECT_ADDR;
  assign xsel_wr = wr_en && addr == EXPANSION_RAM_SIZE_SELECT_ADDR;
  assign msel_rd = rd_en && addr == MEMORY_SIZE_SELECT_ADDR;
  assign xsel_rd = rd_en && addr == EXPANSION_RAM_SIZE_SELECT_ADDR;

  assign {
    fast_work_memory_size_bit2,
    fast_work_memory_size_bit1,
    fast_work_memory_size_bit0
  } = memory_size_select_r[RAM_SEL_MSB:RAM_SEL_LSB];
  assign {
    program_store_size_bit3,
    program_store_size_bit2,
    program_store_size_bit1,
    program_store_size_bit0
  } = memory_size_select_r[ROM_SEL_MSB:0];
  assign {
    extra_memory_size_bit4,
    extra_memory_size_bit3,
    extra_memory_size_bit2,
    extra_memory_size_bit1,
    extra_memory_size_bit0
  } = expansion_ram_size_select_r[XRAM_SEL_MSB:0];

  // Whole-byte writes only; the processor has no narrower path here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      memory_size_select_r <= MEMORY_SIZE_SELECT_RESET;
    end else if (msel_wr) begin
      memory_size_select_r <= wr_data;
      memory_size_select_r[UNUSED_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      expansion_ram_size_select_r <= EXPANSION_RAM_SIZE_SELECT_RESET;
    end else if (xsel_wr) begin
      expansion_ram_size_select_r <= {3'h0, wr_data[XRAM_SEL_MSB:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
      rd_hit <= 1'b0;
    end else begin
      rd_hit <= 1'b0;
      rd_data <= 8'h00;
      if (msel_rd) begin
        rd_data <= memory_size_select_r;
        rd_hit <= 1'b1;
      end else if (xsel_rd) begin
        rd_data <= expansion_ram_size_select_r;
        rd_hit <= 1'b1;
      end
    end
  end

  // Prohibited codes fall back to the largest size and raise a flag
  always_comb begin
    rom_bad = 1'b0;
    case ({
      program_store_size_bit3,
      program_store_size_bit2,
      program_store_size_bit1,
      program_store_size_bit0
    })
      ROM_CODE_8K: rom_nxt = ROM_BYTES_8K;
      ROM_CODE_16K: rom_nxt = ROM_BYTES_16K;
      ROM_CODE_24K: rom_nxt = ROM_BYTES_24K;
      ROM_CODE_32K: rom_nxt = ROM_BYTES_32K;
      ROM_CODE_48K: rom_nxt = ROM_BYTES_48K;
      ROM_CODE_60K: rom_nxt = ROM_BYTES_60K;
      default: begin
        rom_nxt = ROM_BYTES_60K;
        rom_bad = 1'b1;
      end
    endcase
  end

  always_comb begin
    ram_bad = 1'b0;
    case ({
      fast_work_memory_size_bit2,
      fast_work_memory_size_bit1,
      fast_work_memory_size_bit0
    })
      RAM_CODE_512: ram_nxt = RAM_BYTES_512;
      RAM_CODE_1024: ram_nxt = RAM_BYTES_1024;
      default: begin
        ram_nxt = RAM_BYTES_1024;
        ram_bad = 1'b1;
      end
    endcase
  end

  // Only the none and 1024-byte codes are legal; any other code keeps it off
  always_comb begin
    xram_nxt = 1'b0;
    xram_bad = 1'b0;
    case ({
      extra_memory_size_bit4,
      extra_memory_size_bit3,
      extra_memory_size_bit2,
      extra_memory_size_bit1,
      extra_memory_size_bit0
    })
      XRAM_CODE_1024: xram_nxt = 1'b1;
      XRAM_CODE_NONE: xram_nxt = 1'b0;
      default: xram_bad = 1'b1;
    endcase
  end

  assign illegal_nxt = rom_bad || ram_bad || xram_bad;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rom_bytes <= ROM_BYTES_60K;
      ram_bytes <= RAM_BYTES_1024;
      xram_en <= 1'b0;
      sel_illegal <= 1'b0;
    end else begin
      rom_bytes <= rom_nxt;
      ram_bytes <= ram_nxt;
      xram_en <= xram_nxt;
      sel_illegal <= illegal_nxt;
    end
  end

  // Windows follow the stored codes, in step with the size outputs
  always_comb begin
    ram_base = RAM_TOP - 16'(ram_nxt);
    xram_top = XRAM_BASE + 16'(KB);
    rom_hit_nxt = {1'b0, probe_addr} < rom_nxt;
    ram_hit_nxt = probe_addr < RAM_TOP && probe_addr >= ram_base;
    xram_hit_nxt = xram_nxt && probe_addr >= XRAM_BASE && probe_addr < xram_top;
  end

  // Registered classification, one cycle behind probe_addr
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_rom <= 1'b0;
      in_ram <= 1'b0;
      in_xram <= 1'b0;
    end else begin
      in_rom <= rom_hit_nxt;
      in_ram <= ram_hit_nxt;
      in_xram <= xram_hit_nxt;
    end
  end
endmodule : memory_size_config_regs
`default_nettype wire

// ### test/mem_size_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mem_size_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Processor access
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit,
  // Decoder results
  input wire logic xram_en,
  input wire logic sel_illegal,
  input wire logic [16:0] rom_bytes,
  input wire logic [10:0] ram_bytes
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire w0 = wr_en && addr == 16'hfff0;
  wire w4 = wr_en && addr == 16'hfff4;
  property p_rst; $rose(rst_b) |-> rom_bytes == 17'hf000 && !xram_en; endproperty
  a_rst: assert property (p_rst) else $error("reset size");
  property p_rd; rd_en && addr == 16'hfff4 |=> rd_hit && rd_data[7:5] == 3'h0; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_min; w0 && wr_data == 8'h42 |=> ##1 rom_bytes == 17'h2000 && ram_bytes == 11'h200;
  endproperty
  a_min: assert property (p_min) else $error("small");
  property p_max; w0 && wr_data == 8'hcf |=> ##1 rom_bytes == 17'hf000 && !sel_illegal;
  endproperty
  a_max: assert property (p_max) else $error("large");
  property p_bad; w0 && wr_data == 8'hff |=> ##1 sel_illegal; endproperty
  a_bad: assert property (p_bad) else $error("flag");
  property p_xon; w4 && wr_data == 8'h0a |=> ##1 xram_en; endproperty
  a_xon: assert property (p_xon) else $error("xram on");
  property p_xoff; w4 && wr_data == 8'h0c |=> ##1 !xram_en; endproperty
  a_xoff: assert property (p_xoff) else $error("xram off");
  property p_hold; !wr_en ##1 !wr_en |=> $stable(rom_bytes) && $stable(xram_en); endproperty
  a_hold: assert property (p_hold) else $error("drift");
  cover property (rd_hit);
  cover property (xram_en);
  cover property (sel_illegal);
endmodule : mem_size_chk
bind memory_size_config_regs mem_size_chk chk (
  .clk(clk),
  .rst_b(rst_b),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .addr(addr),
  .wr_data(wr_data),
  .rd_data(rd_data),
  .rd_hit(rd_hit),
  .xram_en(xram_en),
  .sel_illegal(sel_illegal),
  .rom_bytes(rom_bytes),
  .ram_bytes(ram_bytes)
);
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst_b = 0, wr_en = 0, rd_en = 0;
  logic rd_hit, xram_en, in_rom, in_ram, in_xram, sel_illegal;
  logic [15:0] addr = 16'h0, probe_addr = 16'h2000;
  logic [7:0] wr_data = 8'h0, rd_data;
  logic [16:0] rom_bytes;
  logic [10:0] ram_bytes;
  int error_cnt = 0, checked = 0;
  // Address, written byte, byte read back
  logic [31:0] rows [10] = '{32'hfff04242, 32'hfff04444, 32'hfff0c6c6, 32'hfff0c8c8,
    32'hfff0cccc, 32'hfff4ff1f, 32'hfff40a0a, 32'hfff40c0c, 32'hfff0ffef, 32'hfff0cfcf};
  memory_size_config_regs uut (
    .clk(clk),
    .rst_b(rst_b),
    .addr(addr),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .rd_hit(rd_hit),
    .probe_addr(probe_addr),
    .rom_bytes(rom_bytes),
    .ram_bytes(ram_bytes),
    .xram_en(xram_en),
    .in_rom(in_rom),
    .in_ram(in_ram),
    .in_xram(in_xram),
    .sel_illegal(sel_illegal)
  );
  always #20 clk = ~clk;
  task chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t: %h not %h", $time, s, e);
    end
  endtask : chk
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
    @(negedge clk);
    {wr_en, rd_en} = 2'h0;
  endtask : acc
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial begin
    #20000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1;
    acc(0, 16'hfff0, 8'h0);
    chk({rd_data, rom_bytes}, {8'hcf, 17'hf000});
    acc(0, 16'hfff4, 8'h0);
    chk({rd_data, xram_en}, {8'h0c, 1'b0});
    $display("reset tests done");
    foreach (rows[i]) begin
      acc(1, rows[i][31:16], rows[i][15:8]);
      acc(0, rows[i][31:16], 8'h0);
      chk({rd_hit, rd_data}, {1'b1, rows[i][7:0]});
    end
    $display("row tests done");
    acc(0, 16'hfff1, 8'h0);
    chk({rd_hit, rd_data}, 9'h0);
    acc(1, 16'hfff0, 8'h42);
    repeat (2) @(negedge clk);
    chk({in_rom, rom_bytes}, {1'b0, 17'h2000});
    chk({ram_bytes, sel_illegal}, {11'h200, 1'b0});
    probe_addr = 16'h1fff;
    @(negedge clk);
    chk(in_rom, 1'b1);
    probe_addr = 16'hfd00;
    @(negedge clk);
    chk(in_ram, 1'b1);
    probe_addr = 16'hfcff;
    @(negedge clk);
    chk(in_ram, 1'b0);
    acc(1, 16'hfff4, 8'h0a);
    probe_addr = 16'hf7ff;
    repeat (2) @(negedge clk);
    chk({xram_en, in_xram}, 2'h3);
    probe_addr = 16'hf800;
    @(negedge clk);
    chk(in_xram, 1'b0);
    acc(1, 16'hfff0, 8'h43);
    repeat (2) @(negedge clk);
    chk({sel_illegal, rom_bytes}, {1'b1, 17'hf000});
    // Smaller part: 32 KB image, no expansion memory
    acc(1, 16'hfff0, 8'hc8);
    acc(1, 16'hfff4, 8'h0c);
    repeat (2) @(negedge clk);
    chk({rom_bytes, ram_bytes, xram_en, sel_illegal}, {17'h8000, 11'h400, 2'h0});
    $display("decode tests done");
    // Mid-run reset must restore both defaults
    acc(1, 16'hfff4, 8'h0a);
    rst_b = 0;
    @(negedge clk);
    rst_b = 1;
    acc(0, 16'hfff0, 8'h0);
    chk(rd_data, 8'hcf);
    acc(0, 16'hfff4, 8'h0);
    chk({rd_data, xram_en}, {8'h0c, 1'b0});
    $display("edge tests done");
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
